/* lsfc_top.sv */
// Operation
// R1: Reverse voltage held for 4 ms turns the switch off.
// R2: Auto-recovery: switch returns after reverse absent for 4 ms.
// R3: Latch-off: reverse shutdown holds switch off until enable toggle or reset.
// R4: Fault indication goes low after reverse persists 4 ms.
// R5: Fault is open-drain active low, for over-current, thermal, reverse.
// R6: Auto-recovery: fault held until condition gone and switch resumed.
// R7: Latch-off: fault held while latched, released by toggle or reset.
// R8: Over-current qualified by 10 ms deglitch before reporting.
// R9: Deglitch delays both entry and exit, needing continuous level.
// R10: Over-temperature asserts fault immediately, no deglitch.
// R11: Undervoltage lockout keeps the switch disabled.
// R12: Enable low disables driver, bias and switch; high enables them.
// R13: Weak enable pull-up while off, strong pull-up once on.
// R14: Output discharge active whenever enable is low.
// R15: At over-current onset the switch stays on in current limit.
// R16: Auto-recovery: after 10 ms, fault and stay in current limit.
// R17: Auto-recovery: thermal input turns switch off until it clears.
// R18: Auto-recovery: normal operation resumes when overload disappears.
// R19: Latch-off: after 10 ms over-current, fault and switch off at once.
// R20: Latch-off: stays off after over-current latch even if overload removed.
// R21: Host recovers latch by toggling enable low then high, or power cycle.
// R22: Timers count a millisecond tick and clear when condition absent.
// R23: Latch cleared by reset or by enable falling then rising.
`timescale 1ns/1ps
`default_nettype none
`include "lsfc_consts.svh"
module lsfc_top
  import lsfc_pkg::*;
#(
  parameter bit LATCH_OFF = 1'b1,
  parameter int TICK_CYC = `LSFC_TICK_CYC,
  parameter int REV_MS = `LSFC_REV_MS,
  parameter int OC_MS = `LSFC_OC_MS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic switch_enable_in,
  input wire logic reverse_in,
  input wire logic overcurrent_in,
  input wire logic overtemp_in,
  input wire logic input_undervoltage_lockout_in,
  output logic gate_enable_out,
  output logic driver_bias_en_out,
  output logic current_limit_out,
  output logic fault_indicator_low_out,
  output logic fault_indicator_low_oe_out,
  output logic discharge_en_out,
  output logic pullup_strong_out
);
  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;

  // Refuse settings the divider and the filter counters cannot serve
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("lsfc_top: TICK_CYC must be at least 2");
  end
  // Filter spans must fit the shared tick counter width
  if (REV_MS < 1 || OC_MS < 1 || REV_MS >= (1 << `LSFC_MS_W) ||
      OC_MS >= (1 << `LSFC_MS_W)) begin : g_bad_span
    $error("lsfc_top: deglitch span out of range");
  end

  // Asynchronous assert, synchronous release
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign raw_in = {input_undervoltage_lockout_in, overtemp_in, overcurrent_in,
                   reverse_in, switch_enable_in};

  // Two flops per pin; only s2 is read by logic
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end

  // Synchronised copies of the pins, one name each
  logic en_s;
  logic rev_s;
  logic oc_s;
  logic ot_s;
  logic uv_s;
  assign en_s = s2_reg[0];
  assign rev_s = s2_reg[1];
  assign oc_s = s2_reg[2];
  assign ot_s = s2_reg[3];
  assign uv_s = s2_reg[4];

  // ==========================================================
  // Millisecond tick divider
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic tick_reg;
  logic tick_next;

  // Free-running phase, so a filter span may end up to one tick early
  always_comb begin
    tick_next = 1'b0;
    div_next = div_reg + 32'h1;
    if (div_reg == 32'(TICK_CYC - 1)) begin
      div_next = 32'h0;
      tick_next = 1'b1; // R22
    end
  end

  // Register the divider
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================================
  // Deglitch filters for reverse and over-current
  lsfc_deglitch_if rev_if ();
  lsfc_deglitch_if oc_if ();
  assign rev_if.tick = tick_reg;
  assign rev_if.raw = rev_s;
  assign oc_if.tick = tick_reg;
  assign oc_if.raw = oc_s;

  // Separate filters: reverse and over-current spans differ
  lsfc_deglitch #(.MS(REV_MS), .W(`LSFC_MS_W)) u_rev_dg (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .dg(rev_if.filt)
  );

  lsfc_deglitch #(.MS(OC_MS), .W(`LSFC_MS_W)) u_oc_dg (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .dg(oc_if.filt)
  );

  logic rev_q;
  logic oc_q;
  assign rev_q = rev_if.qual;
  assign oc_q = oc_if.qual;

  // ==========================================================
  // Switch state machine
  lsfc_state_t state_reg;
  lsfc_state_t state_next;
  logic en_d_reg;
  logic en_rise;
  logic block_on;
  // Rising edge of the synchronised enable
  assign en_rise = en_s && !en_d_reg;
  // Conditions that hold the pass switch off in either variant
  assign block_on = !en_s || uv_s || ot_s || rev_q; // R1 R11 R12 R17

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LSFC_OFF: begin
        if (!block_on) begin
          state_next = LSFC_ON; // R2 R18
        end
      end
      LSFC_ON: begin
        if (LATCH_OFF && en_s && (rev_q || oc_q)) begin
          state_next = LSFC_LATCHED; // R3 R19
        end else if (block_on) begin
          state_next = LSFC_OFF;
        end
      end
      LSFC_LATCHED: begin
        // Only enable going low frees the latch; overload removal does not
        if (!en_s) begin
          state_next = LSFC_OFF; // R20 R23
        end
      end
      default: begin
        state_next = LSFC_OFF;
      end
    endcase
  end

  // Register the state and the enable history
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LSFC_OFF; // R23
      en_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      en_d_reg <= en_s;
    end
  end

  // ==========================================================
  // Output registers
  logic gate_next;
  logic fault_next;
  logic cl_next;
  logic oe_next;
  logic disch_next;
  logic bias_next;

  always_comb begin
    gate_next = (state_next == LSFC_ON); // R12
    // Current limit follows raw over-current while switch conducts
    cl_next = gate_next && oc_s; // R15 R16
    // Fault: qualified over-current, reverse, raw thermal, or latch
    // Over-current masked with enable low, the switch carries no load then
    // Reverse stays reported with the switch off: the output can be back-driven
    fault_next = (en_s && oc_q) || rev_q || ot_s
                 || (state_next == LSFC_LATCHED); // R4 R5 R6 R7 R8 R10
    // Open-drain enable is low while the pin is pulled low
    oe_next = !fault_next; // R5
    bias_next = en_s; // R12
    disch_next = !en_s; // R14
  end

  // Outputs come straight from flops
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gate_enable_out <= 1'b0;
      driver_bias_en_out <= 1'b0;
      current_limit_out <= 1'b0;
      fault_indicator_low_out <= 1'b0;
      fault_indicator_low_oe_out <= 1'b1;
      discharge_en_out <= 1'b1;
      pullup_strong_out <= 1'b0;
    end else begin
      gate_enable_out <= gate_next;
      driver_bias_en_out <= bias_next; // R12
      current_limit_out <= cl_next;
      fault_indicator_low_out <= 1'b0;
      fault_indicator_low_oe_out <= oe_next; // R5
      discharge_en_out <= disch_next; // R14
      pullup_strong_out <= gate_next; // R13
    end
  end

  // ==========================================================
  // Checks
  chk_latch_holds_off: assert property (@(posedge clk_in) disable iff (!rst_n) // R20
    (state_reg == LSFC_LATCHED && en_s) |=> state_reg == LSFC_LATCHED)
    else $error("latch left without enable low");
  chk_latch_faults: assert property (@(posedge clk_in) disable iff (!rst_n) // R7
    (state_reg == LSFC_LATCHED && en_s) |=> !fault_indicator_low_oe_out)
    else $error("fault not shown while latched");
  chk_thermal_fast: assert property (@(posedge clk_in) disable iff (!rst_n) // R10
    ot_s |=> !fault_indicator_low_oe_out)
    else $error("thermal fault not immediate");
  chk_thermal_off: assert property (@(posedge clk_in) disable iff (!rst_n) // R17
    ot_s |=> !gate_enable_out)
    else $error("switch on during thermal shutdown");
  chk_input_undervoltage_lockout_off: assert property (@(posedge clk_in) disable iff (!rst_n) // R11
    uv_s |=> !gate_enable_out)
    else $error("switch on during undervoltage");
  chk_disch_enable: assert property (@(posedge clk_in) disable iff (!rst_n) // R14
    !en_s |=> discharge_en_out && !gate_enable_out)
    else $error("discharge or gate wrong with enable low");
  chk_pullup_gate: assert property (@(posedge clk_in) disable iff (!rst_n) // R13
    pullup_strong_out == gate_enable_out)
    else $error("pull-up select not following switch");
  chk_oc_stays_on: assert property (@(posedge clk_in) disable iff (!rst_n) // R15
    (state_reg == LSFC_ON && !oc_q && !block_on) |=> gate_enable_out)
    else $error("switch dropped before over-current qualified");
  chk_auto_oc_on: assert property (@(posedge clk_in) disable iff (!rst_n) // R16
    (!LATCH_OFF && state_reg == LSFC_ON && oc_q && !block_on) |=> gate_enable_out)
    else $error("auto variant turned off on over-current");
  chk_rev_off: assert property (@(posedge clk_in) disable iff (!rst_n) // R1
    rev_q |=> !gate_enable_out && !fault_indicator_low_oe_out)
    else $error("reverse fault not acted on");
  // A fresh enable edge with nothing blocking must bring the switch back
  chk_en_rise_use: assert property (@(posedge clk_in) disable iff (!rst_n) // R23
    (state_reg == LSFC_OFF && en_rise && !block_on) |=> state_reg == LSFC_ON)
    else $error("enable rise did not restart the switch");
  // Enable low is the first half of the way out of a latch
  chk_latch_release: assert property (@(posedge clk_in) disable iff (!rst_n) // R23
    (state_reg == LSFC_LATCHED && !en_s) |=> state_reg == LSFC_OFF)
    else $error("latch kept with enable low");
  chk_release_disabled: assert property (@(posedge clk_in) disable iff (!rst_n) // R7
    (!en_s && !ot_s && !rev_q) |=> fault_indicator_low_oe_out)
    else $error("fault held with enable low and no cause");
  chk_bias_enable: assert property (@(posedge clk_in) disable iff (!rst_n) // R12
    en_s |=> driver_bias_en_out && !discharge_en_out)
    else $error("bias or discharge wrong with enable high");
  chk_cl_onset: assert property (@(posedge clk_in) disable iff (!rst_n) // R15
    (gate_enable_out && oc_s && !oc_q && !block_on) |=> current_limit_out && gate_enable_out)
    else $error("current limit not held at over-current onset");
endmodule
`default_nettype wire

/* lsfc_consts.svh */
`ifndef LSFC_CONSTS_SVH
`define LSFC_CONSTS_SVH
// Clock and timing
`define LSFC_CLK_HZ 125000000
`define LSFC_TICK_US 1000
`define LSFC_TICK_CYC ((`LSFC_CLK_HZ / 1000000) * `LSFC_TICK_US)
`define LSFC_REV_MS 4
`define LSFC_OC_MS 10
`define LSFC_MS_W 8
`endif

/* lsfc_pkg.sv */
`default_nettype none
package lsfc_pkg;
  typedef enum logic [1:0] {
    LSFC_OFF = 2'b00,
    LSFC_ON = 2'b01,
    LSFC_LATCHED = 2'b10
  } lsfc_state_t;
endpackage
`default_nettype wire

/* lsfc_deglitch_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries one filter's raw input, tick and qualified output
interface lsfc_deglitch_if;
  logic tick;
  logic raw;
  logic qual;
  modport filt (input tick, input raw, output qual);
  modport user (output tick, output raw, input qual);
endinterface
`default_nettype wire

/* lsfc_deglitch.sv */
`timescale 1ns/1ps
`default_nettype none
module lsfc_deglitch #(
  parameter int MS = 4,
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  lsfc_deglitch_if.filt dg
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic qual_reg;
  logic qual_next;

  // Refuse spans that the tick counter cannot reach
  if (MS < 1 || MS >= (1 << W)) begin : g_bad_ms
    $error("lsfc_deglitch: MS out of range");
  end

  // Count ticks while raw differs from the qualified level
  always_comb begin
    cnt_next = cnt_reg;
    qual_next = qual_reg;
    if (dg.raw == qual_reg) begin
      cnt_next = '0; // R22
    end else if (dg.tick) begin
      if (cnt_reg == W'(MS - 1)) begin
        qual_next = dg.raw; // R9
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      qual_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      qual_reg <= qual_next;
    end
  end

  assign dg.qual = qual_reg;

  // A flip of the qualified level needs the raw level to have differed
  chk_qual_needs_raw: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(qual_reg) |-> $past(dg.raw) == qual_reg) // R9
    else $error("qualified level changed without raw level");
endmodule
`default_nettype wire

/* lsfc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side: drives enable, watches fault line
module lsfc_host_model (
  input wire logic clk_in,
  input wire logic fault_low_oe_in,
  input wire logic fault_low_data_in,
  output logic switch_enable_out,
  output logic fault_seen_out
);
  wire logic fault_line;
  // Pull-up wins whenever the device releases the line
  assign fault_line = fault_low_oe_in ? 1'b1 : fault_low_data_in;
  assign fault_seen_out = ~fault_line;
  initial switch_enable_out = 1'b0;
  // Enable only moves off the sampling edge
  task automatic set_en(input logic v);
    @(negedge clk_in);
    switch_enable_out = v;
  endtask
  // Low pulse on enable, the only way out of a latch short of power loss
  task automatic toggle();
    set_en(1'b0);
    repeat (5) @(negedge clk_in);
    set_en(1'b1);
  endtask
endmodule
`default_nettype wire

/* test_load_switch_fault_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_load_switch_fault_control;
  import lsfc_pkg::*;
  // Short tick keeps deglitch spans at 40 to 100 cycles
  localparam int TK = 10;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rev = 1'b0;
  logic oc = 1'b0;
  logic ot = 1'b0;
  logic uv = 1'b0;
  logic [31:0] seed = 32'h01AA;
  logic [1:0] exp_l = 2'h1;
  logic [1:0] exp_a = 2'h1;
  logic [1:0] last_l = 2'h1;
  logic [1:0] last_a = 2'h1;
  logic [1:0] q0 [$];
  logic [1:0] q1 [$];
  int failures = 0;
  int checks_done = 0;
  wire logic en, gate_l, oe_l, gate_a, oe_a, dis, pu, bias, cl, fl, seen;
  // ==========================================
  // Latch-off and auto-recovery copies share all inputs
  lsfc_top #(.LATCH_OFF(1'b1), .TICK_CYC(TK)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .switch_enable_in(en), .reverse_in(rev), .overcurrent_in(oc), .overtemp_in(ot),
    .input_undervoltage_lockout_in(uv), .gate_enable_out(gate_l), .driver_bias_en_out(bias),
    .current_limit_out(cl), .fault_indicator_low_out(fl), .fault_indicator_low_oe_out(oe_l),
    .discharge_en_out(dis), .pullup_strong_out(pu));
  lsfc_top #(.LATCH_OFF(1'b0), .TICK_CYC(TK)) i_auto (.clk_in(clk_in), .nrst_in(nrst_in),
    .switch_enable_in(en), .reverse_in(rev), .overcurrent_in(oc), .overtemp_in(ot),
    .input_undervoltage_lockout_in(uv), .gate_enable_out(gate_a), .driver_bias_en_out(),
    .current_limit_out(), .fault_indicator_low_out(), .fault_indicator_low_oe_out(oe_a),
    .discharge_en_out(), .pullup_strong_out());
  lsfc_host_model host (.clk_in(clk_in), .fault_low_oe_in(oe_l), .fault_low_data_in(fl),
    .switch_enable_out(en), .fault_seen_out(seen));
  always #4 clk_in = ~clk_in;
  // ==========================================
  task automatic check(input logic [31:0] got, input logic [31:0] want_v);
    checks_done++;
    if (got !== want_v) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, want_v);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Note the next {gate, fault_oe} state of each copy, only when it changes
  task automatic want(input logic [1:0] l, input logic [1:0] a);
    if (l !== exp_l) q0.push_back(l);
    if (a !== exp_a) q1.push_back(a);
    exp_l = l;
    exp_a = a;
  endtask
  // Fixed wait, then every noted change must have shown up
  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
    check(32'(q0.size() + q1.size()), 32'h0);
  endtask
  // Any change of state takes the oldest note; a spurious change finds none
  always @(negedge clk_in) begin
    if (nrst_in && {gate_l, oe_l} !== last_l) begin
      check(32'({gate_l, oe_l}), 32'(q0.size() > 0 ? q0.pop_front() : 2'hX));
      last_l = {gate_l, oe_l};
    end
    if (nrst_in && {gate_a, oe_a} !== last_a) begin
      check(32'({gate_a, oe_a}), 32'(q1.size() > 0 ? q1.pop_front() : 2'hX));
      last_a = {gate_a, oe_a};
    end
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  // ==========================================
  initial begin
    repeat (10) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    check(32'({gate_l, oe_l, dis, pu, fl}), 32'h0C);
    host.set_en(1'b1);
    want(2'h3, 2'h3);
    settle(8);
    check(32'({dis, pu, bias}), 32'h3);
    // Random glitches shorter than the shortest filter span
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      if (seed[8]) rev = 1'b1; else oc = 1'b1;
      repeat (1 + seed[4:0] % 20) @(negedge clk_in);
      rev = 1'b0;
      oc = 1'b0;
      repeat (50) @(negedge clk_in);
    end
    settle(1);
    rev = 1'b1;
    want(2'h0, 2'h0);
    settle(60);
    check(32'(seen), 32'h1);
    rev = 1'b0;
    want(2'h0, 2'h3);
    settle(60);
    want(2'h1, 2'h1);
    want(2'h3, 2'h3);
    host.toggle();
    settle(10);
    oc = 1'b1;
    repeat (20) @(negedge clk_in);
    check(32'(cl), 32'h1);
    want(2'h0, 2'h2);
    settle(130);
    check(32'(cl), 32'h0);
    oc = 1'b0;
    want(2'h0, 2'h3);
    settle(130);
    want(2'h1, 2'h1);
    want(2'h3, 2'h3);
    host.toggle();
    settle(10);
    ot = 1'b1;
    want(2'h0, 2'h0);
    settle(6);
    ot = 1'b0;
    want(2'h3, 2'h3);
    settle(6);
    uv = 1'b1;
    want(2'h1, 2'h1);
    settle(6);
    uv = 1'b0;
    want(2'h3, 2'h3);
    settle(6);
    host.set_en(1'b0);
    want(2'h1, 2'h1);
    settle(6);
    check(32'({dis, pu, bias}), 32'h4);
    stop_test();
  end
endmodule
`default_nettype wire
